// >>> pbpja_core.sv
// Page-bounds write protection for states 5..7 and per-state cycle counters.
// Assumes one request per major cycle; all inputs synchronous to clk.
// Operation
// - Three 16-bit bounds registers guard writes of states 5, 6 and 7.
// - Protection works on 256-byte pages from upper address bits.
// - Left byte holds maximum page, right byte holds minimum page.
// - Equal maximum and minimum confine writes to that one page.
// - Bounds value FF00 disables protection for that state.
// - Page above maximum or below minimum flags an addressing violation.
// - Violation traps to control address 010 and suppresses the write.
// - Bounds registers sit at selector 05A0, 05C0 and 05E0.
// - Each cycle increments its state's counter except accounting references.
// - Any write to a counter clears all 32 bits.
// - Four ECC quantities are read-only at 0800..0F00.
`timescale 1ns/1ps
module pbpja_core #(
  parameter int NUM_STATES = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  proc_state,
  input  wire logic        cycle_valid,
  input  wire logic        ro_read,
  input  wire logic        ro_write,
  input  wire logic [15:0] sel_addr,
  input  wire logic [15:0] ro_wdata,
  input  wire logic        ms_write_req,
  input  wire logic [15:0] ecc_mem_data,
  input  wire logic [15:0] ecc_log,
  input  wire logic [15:0] ecc_gen_check,
  input  wire logic [15:0] ecc_read_check,
  output logic [15:0]      ro_rdata,
  output logic             ro_hit,
  output logic             ms_write_en,
  output logic             trap_req,
  output logic [11:0]      trap_addr
);
  // Reject sizes that the fixed address map cannot serve
  if (NUM_STATES != 8) begin : g_bad_states
    $error("pbpja_core serves exactly eight states");
  end

  // Limitation: the write address is checked as given, no relocation applied;
  // the selector page is taken as the target page of the write.

  // Bounds registers, one per protected state
  logic [15:0] state5_page_bounds;
  logic [15:0] state6_page_bounds;
  logic [15:0] state7_page_bounds;

  // Cycle counters, one per processor state
  logic [31:0] state0_cycle_counter;
  logic [31:0] state1_cycle_counter;
  logic [31:0] state2_cycle_counter;
  logic [31:0] state3_cycle_counter;
  logic [31:0] state4_cycle_counter;
  logic [31:0] state5_cycle_counter;
  logic [31:0] state6_cycle_counter;
  logic [31:0] state7_cycle_counter;

  logic [7:0]  page;
  logic        prot_state;
  logic [15:0] active_bounds;
  logic        violation;
  logic        ro_wr_cycle;
  logic        acct_ref;
  logic        acct_clear;
  logic        count_tick;
  logic [2:0]  acct_idx;
  logic [31:0] acct_sel;
  logic        bnd_hit;
  logic        ecc_hit;
  logic [15:0] ecc_sel;
  logic [15:0] next_rdata;
  logic        next_hit;

  // Bounds compare; FF00 means unprotected
  function automatic logic out_of_bounds(input logic [15:0] bnd,
                                         input logic [7:0]  pg);
    if (bnd == pbpja_pkg::BOUNDS_OFF) begin
      return 1'b0;
    end
    // Equal limits pass only that page
    return (pg > bnd[pbpja_pkg::UPPER_MSB:pbpja_pkg::UPPER_LSB]) ||
           (pg < bnd[pbpja_pkg::LOWER_MSB:pbpja_pkg::LOWER_LSB]);
  endfunction : out_of_bounds

  // Both printed addresses of each ECC word decode alike
  function automatic logic [15:0] ecc_key(input logic [15:0] addr);
    return addr & pbpja_pkg::ECC_MASK;
  endfunction : ecc_key

  // Counter decode ignores the state and word fields
  function automatic logic is_acct(input logic [15:0] addr);
    return (addr & pbpja_pkg::ACCT_MASK) == pbpja_pkg::ACCT_BASE;
  endfunction : is_acct

  // Silent modulo-2^32 step, no overflow event
  function automatic logic [31:0] count_step(input logic [31:0] value);
    return value + 32'h0000_0001;
  endfunction : count_step

  // Clear wins over count for the addressed state
  function automatic logic [31:0] next_count(input logic [31:0] value,
                                             input logic        clear,
                                             input logic        tick);
    if (clear) begin
      return pbpja_pkg::COUNT_RESET;
    end
    if (tick) begin
      return count_step(value);
    end
    return value;
  endfunction : next_count

  // Page number is left byte of the selector
  assign page        = sel_addr[15:16-pbpja_pkg::PAGE_BITS];
  assign prot_state  = proc_state >= pbpja_pkg::FIRST_PROT;
  assign ro_wr_cycle = cycle_valid && ro_write;
  assign acct_ref    = is_acct(sel_addr);
  assign acct_idx    = sel_addr[7:5];
  assign acct_clear  = ro_wr_cycle && acct_ref;
  assign count_tick  = cycle_valid && !((ro_read || ro_write) && acct_ref);
  assign bnd_hit     = sel_addr == pbpja_pkg::BOUNDS5_ADDR ||
                       sel_addr == pbpja_pkg::BOUNDS6_ADDR ||
                       sel_addr == pbpja_pkg::BOUNDS7_ADDR;
  assign ecc_hit     = ecc_key(sel_addr) == pbpja_pkg::ECC_MDATA_ADDR ||
                       ecc_key(sel_addr) == pbpja_pkg::ECC_LOG_ADDR ||
                       ecc_key(sel_addr) == pbpja_pkg::ECC_GEN_ADDR ||
                       ecc_key(sel_addr) == pbpja_pkg::ECC_READ_ADDR;

  // States 0..4 see the open value and so never trap
  always_comb begin
    case (proc_state)
      3'h5:    active_bounds = state5_page_bounds;
      3'h6:    active_bounds = state6_page_bounds;
      3'h7:    active_bounds = state7_page_bounds;
      default: active_bounds = pbpja_pkg::BOUNDS_OFF;
    endcase
  end

  assign violation = cycle_valid && ms_write_req && prot_state &&
                     out_of_bounds(active_bounds, page);

  // Counter selected by the address state field
  always_comb begin
    case (acct_idx)
      3'h0:    acct_sel = state0_cycle_counter;
      3'h1:    acct_sel = state1_cycle_counter;
      3'h2:    acct_sel = state2_cycle_counter;
      3'h3:    acct_sel = state3_cycle_counter;
      3'h4:    acct_sel = state4_cycle_counter;
      3'h5:    acct_sel = state5_cycle_counter;
      3'h6:    acct_sel = state6_cycle_counter;
      3'h7:    acct_sel = state7_cycle_counter;
      default: acct_sel = pbpja_pkg::COUNT_RESET;
    endcase
  end

  // ECC words pass straight from the storage side
  always_comb begin
    case (ecc_key(sel_addr))
      pbpja_pkg::ECC_MDATA_ADDR: ecc_sel = ecc_mem_data;
      pbpja_pkg::ECC_LOG_ADDR:   ecc_sel = ecc_log;
      pbpja_pkg::ECC_GEN_ADDR:   ecc_sel = ecc_gen_check;
      pbpja_pkg::ECC_READ_ADDR:  ecc_sel = ecc_read_check;
      default:                   ecc_sel = 16'h0000;
    endcase
  end

  // Read answer; unmapped and non-read cycles give zero
  always_comb begin
    next_rdata = 16'h0000;
    next_hit   = 1'b0;
    if (cycle_valid && ro_read) begin
      if (acct_ref) begin
        next_hit   = 1'b1;
        next_rdata = sel_addr[0] ? acct_sel[15:0] : acct_sel[31:16];
      end else if (bnd_hit) begin
        next_hit = 1'b1;
        case (sel_addr)
          pbpja_pkg::BOUNDS5_ADDR: next_rdata = state5_page_bounds;
          pbpja_pkg::BOUNDS6_ADDR: next_rdata = state6_page_bounds;
          default:                 next_rdata = state7_page_bounds;
        endcase
      end else if (ecc_hit) begin
        next_hit   = 1'b1;
        next_rdata = ecc_sel;
      end
    end
  end

  // Bounds reset to unprotected so boot code is not trapped
  always_ff @(posedge clk) begin
    if (rst) begin
      state5_page_bounds <= pbpja_pkg::BOUNDS_RESET;
    end else if (ro_wr_cycle && sel_addr == pbpja_pkg::BOUNDS5_ADDR) begin
      state5_page_bounds <= ro_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state6_page_bounds <= pbpja_pkg::BOUNDS_RESET;
    end else if (ro_wr_cycle && sel_addr == pbpja_pkg::BOUNDS6_ADDR) begin
      state6_page_bounds <= ro_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state7_page_bounds <= pbpja_pkg::BOUNDS_RESET;
    end else if (ro_wr_cycle && sel_addr == pbpja_pkg::BOUNDS7_ADDR) begin
      state7_page_bounds <= ro_wdata;
    end
  end

  // Clear ignores data and word select
  always_ff @(posedge clk) begin
    if (rst) begin
      state0_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state0_cycle_counter <= next_count(state0_cycle_counter,
                                         acct_clear && acct_idx == 3'h0,
                                         count_tick && proc_state == 3'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state1_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state1_cycle_counter <= next_count(state1_cycle_counter,
                                         acct_clear && acct_idx == 3'h1,
                                         count_tick && proc_state == 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state2_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state2_cycle_counter <= next_count(state2_cycle_counter,
                                         acct_clear && acct_idx == 3'h2,
                                         count_tick && proc_state == 3'h2);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state3_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state3_cycle_counter <= next_count(state3_cycle_counter,
                                         acct_clear && acct_idx == 3'h3,
                                         count_tick && proc_state == 3'h3);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state4_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state4_cycle_counter <= next_count(state4_cycle_counter,
                                         acct_clear && acct_idx == 3'h4,
                                         count_tick && proc_state == 3'h4);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state5_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state5_cycle_counter <= next_count(state5_cycle_counter,
                                         acct_clear && acct_idx == 3'h5,
                                         count_tick && proc_state == 3'h5);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state6_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state6_cycle_counter <= next_count(state6_cycle_counter,
                                         acct_clear && acct_idx == 3'h6,
                                         count_tick && proc_state == 3'h6);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state7_cycle_counter <= pbpja_pkg::COUNT_RESET;
    end else begin
      state7_cycle_counter <= next_count(state7_cycle_counter,
                                         acct_clear && acct_idx == 3'h7,
                                         count_tick && proc_state == 3'h7);
    end
  end

  // Read data registered so it stands one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ro_rdata <= 16'h0000;
    end else begin
      ro_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ro_hit <= 1'b0;
    end else begin
      ro_hit <= next_hit;
    end
  end

  // Write gating at the end of the major cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_write_en <= 1'b0;
    end else begin
      ms_write_en <= cycle_valid && ms_write_req && !violation;
    end
  end

  // Trap pulse; the vector shows only while the pulse stands
  always_ff @(posedge clk) begin
    if (rst) begin
      trap_req <= 1'b0;
    end else begin
      trap_req <= violation;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trap_addr <= 12'h000;
    end else begin
      trap_addr <= violation ? pbpja_pkg::TRAP_ADDR : 12'h000;
    end
  end
endmodule : pbpja_core

// >>> pbpja_pkg.sv
// Package for page-bounds protection and per-state cycle accounting.
// Assumes selector addresses are the low 16 bits of the selector register.
package pbpja_pkg;
  localparam logic [15:0] BOUNDS5_ADDR   = 16'h05A0;
  localparam logic [15:0] BOUNDS6_ADDR   = 16'h05C0;
  localparam logic [15:0] BOUNDS7_ADDR   = 16'h05E0;
  localparam logic [15:0] ACCT_BASE      = 16'h0600;
  localparam logic [15:0] ACCT_MASK      = 16'hFF1E;
  localparam logic [15:0] ECC_MDATA_ADDR = 16'h0800;
  localparam logic [15:0] ECC_LOG_ADDR   = 16'h0A00;
  localparam logic [15:0] ECC_GEN_ADDR   = 16'h0C00;
  localparam logic [15:0] ECC_READ_ADDR  = 16'h0E00;
  localparam logic [15:0] ECC_MASK       = 16'hFEFF;
  localparam logic [15:0] BOUNDS_OFF     = 16'hFF00;
  localparam logic [15:0] BOUNDS_RESET   = 16'hFF00;
  localparam logic [11:0] TRAP_ADDR      = 12'h010;
  localparam int          PAGE_BITS      = 8;
  localparam int          UPPER_MSB      = 15;
  localparam int          UPPER_LSB      = 8;
  localparam int          LOWER_MSB      = 7;
  localparam int          LOWER_LSB      = 0;
  localparam logic [2:0]  FIRST_PROT     = 3'h5;
  localparam logic [31:0] COUNT_RESET    = 32'h0000_0000;
endpackage : pbpja_pkg

// >>> pbpja_core_properties.sv
// Port checker for pbpja_core.
// Assumes one-cycle registered answers to requests taken with cycle_valid.
`timescale 1ns/1ps
module pbpja_core_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cycle_valid,
  input wire logic        ro_read,
  input wire logic        ms_write_req,
  input wire logic        ro_hit,
  input wire logic        ms_write_en,
  input wire logic        trap_req,
  input wire logic [2:0]  proc_state,
  input wire logic [15:0] sel_addr,
  input wire logic [15:0] ecc_log,
  input wire logic [15:0] ro_rdata,
  input wire logic [11:0] trap_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr = cycle_valid && ms_write_req;
  AST_TRAP_ADDR: assert property (trap_req |-> trap_addr == 12'h010)
    else $error("trap address wrong");
  AST_NO_BOTH: assert property (!(trap_req && ms_write_en))
    else $error("trapped write still enabled");
  AST_WR_CAUSE: assert property (ms_write_en |-> $past(wr))
    else $error("write enable without request");
  AST_LOW_STATES: assert property (wr && proc_state < 3'h5 |=> ms_write_en)
    else $error("low state write blocked");
  AST_TRAP_STATE: assert property (trap_req |-> $past(wr) && $past(proc_state) >= 3'h5)
    else $error("trap outside protected states");
  AST_ECC_LOG: assert property (cycle_valid && ro_read && sel_addr inside {16'h0A00, 16'h0B00}
    |=> ro_hit && ro_rdata == $past(ecc_log))
    else $error("log word read wrong");
  AST_UNMAPPED: assert property (cycle_valid && ro_read && sel_addr == 16'h0400
    |=> !ro_hit && ro_rdata == 16'h0000)
    else $error("unmapped read answered");
  AST_IDLE: assert property (!cycle_valid |=> !ms_write_en && !trap_req && !ro_hit)
    else $error("answer without a major cycle");
  cover property (trap_req);
  cover property (ms_write_en);
  cover property (ro_hit);
endmodule : pbpja_core_properties
bind pbpja_core pbpja_core_properties u_chk (.*);

// >>> pbpja_store_model.sv
// Main-storage write path and ECC source facing pbpja_core.
// Assumes permitted writes are counted on the rising edge.
`timescale 1ns/1ps
module pbpja_store_model (
  input  wire logic clk,
  input  wire logic ms_write_en,
  output logic [15:0] ecc_log = 16'h5A3C,
  output int          n_store = 0
);
  // Log word moves every cycle so a stale capture shows up
  always @(posedge clk) ecc_log <= ecc_log + 16'h1111;
  always @(posedge clk) n_store <= n_store + int'(ms_write_en);
endmodule : pbpja_store_model

// >>> pbpja_core_test.sv
// Self-checking bench for pbpja_core.
// Assumes a 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pbpja_core_test;
  logic clk = 0, rst = 1, cycle_valid = 0, ro_read = 0, ro_write = 0, ms_write_req = 0;
  logic [2:0] proc_state = 0, fl_q;
  logic [15:0] sel_addr = 0, ro_wdata = 0, ecc_log, ro_rdata, rd_q;
  logic [15:0] ecc_mem_data = 16'h1234, ecc_gen_check = 16'h00C3, ecc_read_check = 16'h003C;
  logic ro_hit, ms_write_en, trap_req;
  logic [11:0] trap_addr, ta_q;
  int n_mismatch = 0, total_checks = 0, n_store;
  pbpja_core u_pbpja_core (.*);
  pbpja_store_model u_pbpja_store_model (.*);
  always #10 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One major cycle, then an idle one so no input is assigned twice per step
  task automatic cyc(input logic [2:0] st, input logic rd, wr, mw, input logic [15:0] a, d);
    cycle_valid <= 1; proc_state <= st; ro_read <= rd; ro_write <= wr; ms_write_req <= mw;
    sel_addr <= a; ro_wdata <= d;
    @(posedge clk);
    cycle_valid <= 0; ro_read <= 0; ro_write <= 0; ms_write_req <= 0;
    #1 rd_q = ro_rdata; fl_q = {ro_hit, ms_write_en, trap_req}; ta_q = trap_addr;
    @(posedge clk);
  endtask : cyc
  task automatic mw(input logic [2:0] st, input logic [7:0] pg, input logic ok);
    cyc(st, 0, 0, 1, {pg, 8'h00}, 16'h0000);
    chk({13'h0, fl_q}, {14'h0, ok, ~ok});
    chk({4'h0, ta_q}, ok ? 16'h0000 : 16'h0010);
  endtask : mw
  task automatic t_bounds();
    cyc(5, 0, 1, 0, 16'h05A0, 16'h2010);
    cyc(5, 1, 0, 0, 16'h05A0, 16'h0000);
    chk(rd_q, 16'h2010);
    mw(5, 8'h21, 0); mw(5, 8'h20, 1); mw(5, 8'h10, 1); mw(5, 8'h0F, 0);
    cyc(6, 0, 1, 0, 16'h05C0, 16'h4040);
    mw(6, 8'h40, 1); mw(6, 8'h41, 0); mw(6, 8'h3F, 0);
  endtask : t_bounds
  task automatic t_misc();
    cyc(7, 1, 0, 0, 16'h05E0, 16'h0000);
    chk(rd_q, 16'hFF00);
    mw(7, 8'hFF, 1); mw(7, 8'h00, 1); mw(3, 8'hFF, 1);
    cyc(1, 0, 1, 0, 16'h0800, 16'hFFFF);
    chk(n_store[15:0], 16'h0006);
    cyc(1, 1, 0, 0, 16'h0800, 16'h0000);
    chk(rd_q, 16'h1234);
    cyc(1, 1, 0, 0, 16'h0B00, 16'h0000);
    chk({13'h0, fl_q}, 16'h0004);
    cyc(1, 1, 0, 0, 16'h0D00, 16'h0000);
    chk(rd_q, 16'h00C3);
    cyc(1, 1, 0, 0, 16'h0E00, 16'h0000);
    chk(rd_q, 16'h003C);
    cyc(1, 1, 0, 0, 16'h0400, 16'h0000);
    chk({13'h0, fl_q}, 16'h0000);
  endtask : t_misc
  task automatic t_acct();
    cyc(2, 0, 1, 0, 16'h0641, 16'hFFFF);
    repeat (5) cyc(2, 0, 0, 0, 16'h0000, 16'h0000);
    cyc(2, 1, 0, 0, 16'h0641, 16'h0000);
    chk(rd_q, 16'h0005);
    cyc(2, 1, 0, 0, 16'h0640, 16'h0000);
    chk(rd_q, 16'h0000);
    cyc(2, 1, 0, 0, 16'h0641, 16'h0000);
    chk(rd_q, 16'h0005);
  endtask : t_acct
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_bounds(); t_misc(); t_acct();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule : pbpja_core_test
